// [hw/rcd_map.svh]
// Constants for the command parity and power-down register pair
`ifndef RCD_MAP_SVH
`define RCD_MAP_SVH
// ********************
// Widths and fields
// ********************
`define AC_W          22
`define CW_IDX_LSB    0
`define CW_IDX_MSB    3
`define CW_DATA_LSB   16
`define CW_DATA_MSB   17
`define CW_IDX_FLOAT  4'h1
`define CW_IDX_POWER  4'h9
`define PWR_KEEP_BIT  0
`define PWR_PDEN_BIT  1
// ********************
// Timing
// ********************
`define TCK_NS        10
`define ERR_LOW_TCK   2
`define IN_DIS_TCK    2
`define Q_DIS_TCK     1
`define FIXED_TCK     3
`define ACT_NS        200
`define STAB_NS       2000
`define ACT_CYC       ((`ACT_NS + `TCK_NS - 1) / `TCK_NS)
`define STAB_CYC      ((`STAB_NS + `TCK_NS - 1) / `TCK_NS)
// ********************
// Host registers
// ********************
`define HOST_CMD_OFS    12'h000
`define HOST_CTRL_OFS   12'h004
`define HOST_STAT_OFS   12'h008
`define CMD_CS_LSB      22
`define CMD_BADPAR_BIT  26
`define CTRL_CKE_LSB    0
`define CTRL_ODT_LSB    2
`define CTRL_RUN_BIT    4
`define CTRL_QUAD_BIT   5
`define STAT_BUSY_BIT   0
`define STAT_SEEN_BIT   1
`define STAT_LEVEL_BIT  2
`endif

// [hw/rcd_pkg.sv]
// Types shared by both ends of the register link
`default_nettype none
package rcd_pkg;
  typedef logic [21:0] ac_word_t;
  typedef enum logic [1:0] {PD_RUN, PD_ACTIVE, PD_EXIT} pd_state_t;
  typedef enum logic [1:0] {H_IDLE, H_ACT, H_STAB} host_state_t;
endpackage
`default_nettype wire

// [hw/rcd_link_if.sv]
// Link between memory controller end and register device end
`timescale 1ns/1ps
`default_nettype none
interface rcd_link_if (
  input wire logic ref_clk
);
  logic [21:0] addr_cmd;
  logic        parity_in;
  logic [3:0]  rank_select_in;
  logic [1:0]  clock_enable_in;
  logic [1:0]  termination_ctl_in;
  logic        clock_run;
  logic        four_rank_select_mode;
  logic        err_in;
  logic        err_out;
  logic        err_oe_n;
  logic        parity_error_out_n;

  // Open-drain line with pull-up
  assign parity_error_out_n = err_oe_n ? 1'b1 : err_out;
  assign err_in = parity_error_out_n;

  modport device (
    input  addr_cmd, parity_in, rank_select_in, clock_enable_in,
    input  termination_ctl_in, clock_run, four_rank_select_mode, err_in,
    output err_out, err_oe_n
  );
  modport host (
    output addr_cmd, parity_in, rank_select_in, clock_enable_in,
    output termination_ctl_in, clock_run, four_rank_select_mode,
    input  parity_error_out_n
  );
endinterface
`default_nettype wire

// [hw/parity_checker.sv]
// Even-parity check and open-drain error timing
`timescale 1ns/1ps
`default_nettype none
`include "rcd_map.svh"
module parity_checker
  import rcd_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     rst,
  input  wire logic     run,
  input  wire ac_word_t word_reg,
  input  wire logic     qual,
  input  wire logic     parity_in,
  input  wire logic     par_en,
  output logic          word_bad,
  output logic          err_oe_n
);
  ac_word_t word_d;
  logic     qual_d;
  logic     par_reg;
  logic     hit;
  logic     hold;

  // Pair parity with the word from one cycle earlier
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_d  <= '0;
      qual_d  <= 1'b0;
      par_reg <= 1'b0;
    end else if (run) begin
      word_d  <= word_reg;
      qual_d  <= qual;
      par_reg <= par_en ? parity_in : 1'b0;
    end
  end

  // Odd total of ones across word plus parity is a mismatch
  assign word_bad = qual_d & (^{word_d, par_reg});

  // Error seen at edge two, line low from edge three
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hit      <= 1'b0;
      hold     <= 1'b0;
      err_oe_n <= 1'b1;
    end else if (run) begin
      hit <= word_bad;
      if (hit) begin
        err_oe_n <= 1'b0;
        hold     <= 1'((`ERR_LOW_TCK) - 1);
      end else if (hold) begin
        hold <= 1'b0;
      end else begin
        err_oe_n <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/rcd_device.sv]
// Register device end: parity check, control words, power saving
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rcd_map.svh"
module rcd_device
  import rcd_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst,
  rcd_link_if.device link,
  output ac_word_t   address_out,
  output logic [3:0] rank_select_out,
  output logic [3:0] clock_enable_out,
  output logic [1:0] termination_ctl_out,
  output logic       ac_oe_n,
  output logic       cs_oe_n,
  output logic       odt_oe_n,
  output logic       input_bus_termination
);
  // ********************
  // Input capture
  // ********************
  ac_word_t  word_reg;
  logic [3:0] cs_reg;
  logic [1:0] cke_reg;
  logic [1:0] cke_last;
  logic [1:0] odt_reg;
  logic       run;
  logic       addr_en;
  logic       par_en;
  logic       word_bad;
  logic       err_oe_q;
  pd_state_t  pd_state;
  logic [3:0] pd_cnt;
  logic [3:0] fix_cnt;
  logic       float_en;
  logic [1:0] power_control_word;
  logic       cw_pend;
  logic [3:0] cw_idx;
  logic [1:0] cw_data;
  logic       ibt_off_pd;
  logic       cke_rise;

  // Control-word access: all relevant selects low together
  function automatic logic cw_access(input logic [3:0] cs, input logic quad);
    cw_access = quad ? (cs == 4'h0) : (cs[1:0] == 2'h0);
  endfunction

  assign run        = link.clock_run;
  assign ibt_off_pd = (pd_state == PD_ACTIVE) & ~power_control_word[`PWR_KEEP_BIT];
  // Counter starts two edges after both enables latch low, so limits are offset
  assign addr_en    = ~(ibt_off_pd & (pd_cnt >= 4'(`IN_DIS_TCK - 2)));
  assign par_en     = ~(ibt_off_pd & (pd_cnt >= 4'(`IN_DIS_TCK - 1)));
  assign cke_rise   = link.clock_enable_in != 2'h0;

  // Stopped clock freezes all capture; nothing toggles in standby
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_reg <= '0;
      cs_reg   <= 4'hF;
      cke_reg  <= 2'h0;
      cke_last <= 2'h0;
      odt_reg  <= 2'h0;
    end else if (run) begin
      cke_reg  <= link.clock_enable_in;
      cke_last <= cke_reg;
      odt_reg  <= link.termination_ctl_in;
      if (addr_en) begin
        word_reg <= link.addr_cmd;
        cs_reg   <= link.rank_select_in;
      end else begin
        cs_reg   <= 4'hF;     // Disabled receivers read as deselect
      end
    end
  end

  parity_checker u_parity (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .run       (run),
    .word_reg  (word_reg),
    .qual      (~&cs_reg),
    .parity_in (link.parity_in),
    .par_en    (par_en),
    .word_bad  (word_bad),
    .err_oe_n  (err_oe_q)
  );
  assign link.err_oe_n = err_oe_q;
  assign link.err_out  = 1'b0;

  // ********************
  // Control words
  // ********************
  // Write held one cycle until its parity is known
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cw_pend            <= 1'b0;
      cw_idx             <= 4'h0;
      cw_data            <= 2'h0;
      float_en           <= 1'b0;
      power_control_word <= 2'h0;
    end else if (run) begin
      cw_pend <= cw_access(cs_reg, link.four_rank_select_mode);
      cw_idx  <= word_reg[`CW_IDX_MSB:`CW_IDX_LSB];
      cw_data <= word_reg[`CW_DATA_MSB:`CW_DATA_LSB];
      if (cw_pend && !word_bad) begin
        if (cw_idx == `CW_IDX_FLOAT) begin
          float_en <= cw_data[0];
        end else if (cw_idx == `CW_IDX_POWER) begin
          power_control_word <= cw_data;
        end
      end
    end
  end

  // ********************
  // Power-down sequencing
  // ********************
  // Entry needs both low now and one of them high before
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pd_state <= PD_RUN;
      pd_cnt   <= 4'h0;
      fix_cnt  <= 4'h0;
    end else if (run) begin
      case (pd_state)
        PD_RUN: begin
          pd_cnt <= 4'h0;
          if (power_control_word[`PWR_PDEN_BIT] && cke_reg == 2'h0 && cke_last != 2'h0) begin
            pd_state <= PD_ACTIVE;
          end
        end
        PD_ACTIVE: begin
          if (pd_cnt != 4'hF) begin
            pd_cnt <= pd_cnt + 4'h1;
          end
          if (cke_rise) begin
            pd_state <= PD_EXIT;
            fix_cnt  <= 4'(`FIXED_TCK - 1);
          end
        end
        PD_EXIT: begin
          if (fix_cnt == 4'h0) begin
            pd_state <= PD_RUN;
          end else begin
            fix_cnt <= fix_cnt - 4'h1;
          end
        end
        default: pd_state <= PD_RUN;
      endcase
    end
  end

  // ********************
  // Output stage
  // ********************
  // Reset first, then stopped clock, then power-down state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      address_out           <= '0;
      rank_select_out       <= 4'hF;
      clock_enable_out      <= 4'h0;
      termination_ctl_out   <= 2'h0;
      ac_oe_n               <= 1'b1;
      cs_oe_n               <= 1'b1;
      odt_oe_n              <= 1'b1;
      input_bus_termination <= 1'b0;
    end else if (!run) begin
      clock_enable_out <= 4'h0;
      ac_oe_n          <= 1'b1;
      cs_oe_n          <= 1'b1;
      odt_oe_n         <= 1'b1;
    end else begin
      input_bus_termination <= ~ibt_off_pd;
      case (pd_state)
        PD_RUN: begin
          address_out         <= word_reg;
          rank_select_out     <= cw_access(cs_reg, link.four_rank_select_mode) ? 4'hF : cs_reg;
          clock_enable_out    <= {cke_reg, cke_reg};
          termination_ctl_out <= odt_reg;
          ac_oe_n             <= float_en & (&cs_reg);
          cs_oe_n             <= 1'b0;
          odt_oe_n            <= 1'b0;
        end
        PD_ACTIVE: begin
          if (cke_rise) begin
            clock_enable_out    <= {link.clock_enable_in, link.clock_enable_in};
            rank_select_out     <= 4'hF;
            termination_ctl_out <= 2'h0;
            address_out         <= '0;
            ac_oe_n             <= 1'b0;
            cs_oe_n             <= 1'b0;
          end else begin
            clock_enable_out <= 4'h0;
            if (ibt_off_pd) begin
              termination_ctl_out <= 2'h0;
              ac_oe_n <= pd_cnt >= 4'(`Q_DIS_TCK - 1);
              cs_oe_n <= pd_cnt >= 4'(`Q_DIS_TCK - 1);
            end else begin
              termination_ctl_out <= odt_reg;
            end
          end
        end
        PD_EXIT: begin
          clock_enable_out    <= {cke_reg, cke_reg};
          rank_select_out     <= cs_reg;
          termination_ctl_out <= 2'h0;
          address_out         <= '0;
        end
        default: ac_oe_n <= 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

// [hw/rcd_host.sv]
// Memory controller end: APB registers drive the command link
`timescale 1ns/1ps
`default_nettype none
`include "rcd_map.svh"
module rcd_host
  import rcd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  rcd_link_if.host         link
);
  host_state_t st;
  logic [7:0]  cnt;
  logic [1:0]  cke;
  logic [1:0]  odt;
  logic        run_req;
  logic        quad;
  logic        par_next;
  logic        seen;
  logic        busy;
  logic        wr;
  logic        known;
  logic [3:0]  cs_cmd;

  assign busy   = st != H_IDLE;
  assign wr     = psel & penable & pwrite & pready;
  assign known  = paddr == `HOST_CMD_OFS || paddr == `HOST_CTRL_OFS || paddr == `HOST_STAT_OFS;
  assign cs_cmd = pwdata[`CMD_CS_LSB +: 4];

  // ********************
  // APB answer
  // ********************
  // No wait states: answer registered in the setup cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      prdata  <= 32'h0000_0000;
      if (paddr == `HOST_CTRL_OFS) begin
        prdata[5:0] <= {quad, run_req, odt, cke};
      end else if (paddr == `HOST_STAT_OFS) begin
        prdata[2:0] <= {~link.parity_error_out_n, seen, busy};
      end
    end
  end

  // Sticky error flag; a new error beats write-one-to-clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen <= 1'b0;
    end else if (!link.parity_error_out_n) begin
      seen <= 1'b1;
    end else if (wr && paddr == `HOST_STAT_OFS && pwdata[`STAT_SEEN_BIT]) begin
      seen <= 1'b0;
    end
  end

  // ********************
  // Link drive
  // ********************
  // CKE and ODT are always driven, never floated
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.addr_cmd              <= '0;
      link.rank_select_in        <= 4'hF;
      link.clock_enable_in       <= 2'h0;
      link.termination_ctl_in    <= 2'h0;
      link.parity_in             <= 1'b0;
      link.clock_run             <= 1'b1;
      link.four_rank_select_mode <= 1'b0;
      par_next <= 1'b0;
      cke      <= 2'h0;
      odt      <= 2'h0;
      run_req  <= 1'b1;
      quad     <= 1'b0;
      st       <= H_IDLE;
      cnt      <= 8'h00;
    end else begin
      link.parity_in             <= par_next;
      link.rank_select_in        <= 4'hF;
      link.four_rank_select_mode <= quad;
      link.termination_ctl_in    <= odt;
      link.clock_enable_in       <= (st == H_IDLE) ? cke : 2'h0;
      if (wr && paddr == `HOST_CTRL_OFS) begin
        cke     <= pwdata[`CTRL_CKE_LSB +: 2];
        odt     <= pwdata[`CTRL_ODT_LSB +: 2];
        quad    <= pwdata[`CTRL_QUAD_BIT];
        run_req <= pwdata[`CTRL_RUN_BIT];
        if (!pwdata[`CTRL_RUN_BIT]) begin
          link.clock_run <= 1'b0;
          st             <= H_IDLE;
        end else if (!link.clock_run) begin
          st  <= H_ACT;
          cnt <= 8'(`ACT_CYC);
        end
      end
      if (wr && paddr == `HOST_CMD_OFS && !busy && link.clock_run) begin
        link.addr_cmd <= pwdata[`AC_W-1:0];
        par_next      <= ^{pwdata[`AC_W-1:0], pwdata[`CMD_BADPAR_BIT]};
        // Control-word access refused while CKE is low
        if (cke == 2'h0 && (quad ? cs_cmd == 4'h0 : cs_cmd[1:0] == 2'h0)) begin
          link.rank_select_in <= 4'hF;
        end else begin
          link.rank_select_in <= cs_cmd;
        end
      end
      // Restart: deselect with CKE low, then let clock settle
      case (st)
        H_ACT: begin
          if (cnt == 8'h00) begin
            link.clock_run <= 1'b1;
            st             <= H_STAB;
            cnt            <= 8'(`STAB_CYC);
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        H_STAB: begin
          if (cnt == 8'h00) begin
            st <= H_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          // Idle must not touch the count a restart request has just loaded
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [verif/cmd_parity_and_powerdown_ctrl_checker.sv]
// Checker for the command link between controller and register device
`timescale 1ns/1ps
`default_nettype none
module cmd_parity_and_powerdown_ctrl_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [21:0] addr_cmd,
  input wire logic        parity_in,
  input wire logic [3:0]  rank_select_in,
  input wire logic [1:0]  clock_enable_in,
  input wire logic        clock_run,
  input wire logic        four_rank_select_mode,
  input wire logic        err_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************
  // Parity tracking
  // ****************
  logic [21:0] word_q;
  logic        sel_q;
  logic        bad;
  // Keep last word, since its parity bit arrives a cycle later
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_q <= 22'h0;
      sel_q  <= 1'b0;
    end else begin
      word_q <= addr_cmd;
      sel_q  <= clock_run && (four_rank_select_mode ? rank_select_in != 4'hF : rank_select_in[1:0] != 2'h3);
    end
  end
  // Odd count over word plus parity bit
  assign bad = sel_q && (^{word_q, parity_in});
  // ****************
  // Error line
  // ****************
  chk_err_onset: assert property (bad |-> ##3 !err_oe_n)
    else $error("error line not low three edges after a bad word");
  chk_err_cause: assert property ($fell(err_oe_n) |-> $past(bad, 3))
    else $error("error line fell without a bad selected word");
  chk_err_hold: assert property ($fell(err_oe_n) |=> !err_oe_n)
    else $error("error line low for less than two cycles");
  chk_err_release: assert property (bad ##1 !bad [*4] |=> err_oe_n)
    else $error("error line not released after last bad word");
  chk_reset_err: assert property (disable iff (1'b0) rst |-> err_oe_n)
    else $error("error line low during reset");
  // ****************
  // Controller side
  // ****************
  chk_restart_quiet: assert property ($rose(clock_run) |->
    (rank_select_in == 4'hF && clock_enable_in == 2'h0) ##1 (rank_select_in == 4'hF) [*8])
    else $error("clock restarted without deselect and low enables");
  chk_pd_no_cw: assert property ($changed(clock_enable_in == 2'h0) && !four_rank_select_mode |->
    rank_select_in[1:0] != 2'h0)
    else $error("control word select pattern at power-down edge");
  chk_exit_selects: assert property ($fell(clock_enable_in == 2'h0) |->
    (four_rank_select_mode ? $countones(~rank_select_in) <= 2 : $countones(~rank_select_in[1:0]) <= 1))
    else $error("too many selects at power-down exit");
  cov_bad: cover property (bad);
  cov_restart: cover property ($rose(clock_run));
  cov_exit: cover property ($fell(clock_enable_in == 2'h0));
endmodule
`default_nettype wire

// [verif/cmd_parity_and_powerdown_ctrl_tb.sv]
// Self-checking bench for the controller and register device pair
`timescale 1ns/1ps
`default_nettype none
`include "rcd_map.svh"
module cmd_parity_and_powerdown_ctrl_tb
  import rcd_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ac_word_t    address_out;
  logic [3:0]  rank_select_out;
  logic [3:0]  clock_enable_out;
  logic [1:0]  termination_ctl_out;
  logic        ac_oe_n;
  logic        cs_oe_n;
  logic        odt_oe_n;
  logic        input_bus_termination;
  logic [31:0] rd;
  logic [64:0] exp_q[$];
  logic [64:0] e_now;
  ac_word_t    w;
  ac_word_t    seen;
  int          len;
  int          err_total = 0;
  int          checked = 0;
  always #5 ref_clk = ~ref_clk;
  rcd_link_if link (.ref_clk);
  rcd_host i_rcd_host (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .link(link));
  rcd_device i_rcd_device (.ref_clk, .rst, .link(link), .address_out, .rank_select_out, .clock_enable_out,
    .termination_ctl_out, .ac_oe_n, .cs_oe_n, .odt_oe_n, .input_bus_termination);
  cmd_parity_and_powerdown_ctrl_checker i_cmd_parity_and_powerdown_ctrl_checker (.ref_clk, .rst,
    .addr_cmd(link.addr_cmd), .parity_in(link.parity_in), .rank_select_in(link.rank_select_in),
    .clock_enable_in(link.clock_enable_in), .clock_run(link.clock_run),
    .four_rank_select_mode(link.four_rank_select_mode), .err_oe_n(link.err_oe_n));
  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic give_up();
    err_total++;
    $display("ERROR at %0t: wait ran out", $time);
    print_verdict();
  endtask
  // One APB transfer; a read with nonzero mask queues {slverr, mask, value}
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d, input logic [64:0] x);
    int n;
    @(posedge ref_clk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= wr;
    pwdata <= d;
    if (!wr && x[63:32] != 32'h0) exp_q.push_back(x);
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 20) give_up();
    end while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll until the command engine is free; a long clock restart can keep it busy
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(`HOST_STAT_OFS, 1'b0, 32'h0, 65'h0);
      n++;
      if (n > 300) give_up();
    end while (rd[`STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic cmd(input logic [3:0] sel, input ac_word_t cw, input logic badp);
    wait_idle();
    apb(`HOST_CMD_OFS, 1'b1, {5'h0, badp, sel, cw}, 65'h0);
  endtask
  task automatic ctrl(input logic run, input logic [1:0] cke);
    apb(`HOST_CTRL_OFS, 1'b1, {26'h0, 1'b0, run, 2'h3, cke}, 65'h0);
  endtask
  // Counts edges with the error line low; bounded so a silent line gives zero
  task automatic err_len();
    int n;
    n = 0;
    len = 0;
    while (link.parity_error_out_n !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    while (link.parity_error_out_n === 1'b0 && len < 20) begin
      @(posedge ref_clk);
      len++;
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, err_total);
  endtask
  // Read answers are compared against the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      e_now = exp_q.pop_front();
      check({31'h0, pslverr}, {31'h0, e_now[64]});
      check(prdata & e_now[63:32], e_now[31:0]);
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(43));
    rst <= 1'b1;                 // Real edge at time zero so reset acts at once
    repeat (4) @(posedge ref_clk);
    check({clock_enable_out, ac_oe_n, cs_oe_n, odt_oe_n, input_bus_termination, link.parity_error_out_n}, 32'h1D);
    @(posedge ref_clk);
    rst <= 1'b0;
    apb(12'h0FC, 1'b0, 32'h0, {1'b1, 32'hFFFFFFFF, 32'h0});
    ctrl(1'b1, 2'h3);
    w = ac_word_t'($urandom);
    cmd(4'hE, w, 1'b1);
    err_len();
    check(len, `ERR_LOW_TCK);
    apb(`HOST_STAT_OFS, 1'b0, 32'h0, {1'b0, 32'h6, 32'h2});
    apb(`HOST_STAT_OFS, 1'b1, 32'h2, 65'h0);
    apb(`HOST_STAT_OFS, 1'b0, 32'h0, {1'b0, 32'h6, 32'h0});
    cmd(4'hF, ac_word_t'($urandom), 1'b1);
    err_len();
    check(len, 0);
    cmd(4'hD, ac_word_t'($urandom), 1'b0);
    err_len();
    check(len, 0);
    done("parity");
    // Bad float word must be dropped, good one applied
    cmd(4'hC, {4'h0, 2'h1, 12'h0, `CW_IDX_FLOAT}, 1'b1);
    err_len();
    check(len, `ERR_LOW_TCK);
    settle();
    check(ac_oe_n, 1'b0);
    cmd(4'hC, {4'h0, 2'h1, 12'h0, `CW_IDX_FLOAT}, 1'b0);
    settle();
    check(ac_oe_n, 1'b1);
    w = ac_word_t'($urandom);
    cmd(4'hE, w, 1'b0);
    seen = 22'h0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      if (ac_oe_n === 1'b0) seen = address_out;
    end
    check(seen, w);
    done("float");
    // Power-down with termination off, then exit
    cmd(4'hC, {4'h0, 2'h2, 12'h0, `CW_IDX_POWER}, 1'b0);
    ctrl(1'b1, 2'h0);
    settle();
    check({clock_enable_out, termination_ctl_out, ac_oe_n, cs_oe_n, odt_oe_n, input_bus_termination}, 32'h00C);
    ctrl(1'b1, 2'h1);
    len = 0;
    while (clock_enable_out === 4'h0 && len < 20) begin
      @(posedge ref_clk);
      len++;
    end
    if (len >= 20) give_up();
    check({rank_select_out, termination_ctl_out}, 32'h3C);
    settle();
    check(clock_enable_out, 32'h5);
    // Keep-on variant leaves termination enabled
    cmd(4'hC, {4'h0, 2'h3, 12'h0, `CW_IDX_POWER}, 1'b0);
    ctrl(1'b1, 2'h0);
    settle();
    check({clock_enable_out, input_bus_termination}, 32'h1);
    ctrl(1'b1, 2'h3);
    cmd(4'hC, {4'h0, 2'h0, 12'h0, `CW_IDX_POWER}, 1'b0);
    done("power-down");
    // Clock stop keeps the float word
    ctrl(1'b0, 2'h0);
    settle();
    check({clock_enable_out, ac_oe_n, cs_oe_n, odt_oe_n}, 32'h07);
    ctrl(1'b1, 2'h0);
    wait_idle();
    ctrl(1'b1, 2'h3);
    settle();
    check(ac_oe_n, 1'b1);
    done("clock stop");
    // Reset in mid-run clears control words
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({clock_enable_out, ac_oe_n, cs_oe_n, odt_oe_n, input_bus_termination, link.parity_error_out_n}, 32'h1D);
    rst <= 1'b0;
    ctrl(1'b1, 2'h3);
    settle();
    check(ac_oe_n, 1'b0);
    done("reset");
    // Quad mode: only all four selects low reach the control words
    apb(`HOST_CTRL_OFS, 1'b1, 32'h0000_003F, 65'h0);
    cmd(4'hC, {4'h0, 2'h1, 12'h0, `CW_IDX_FLOAT}, 1'b0);
    settle();
    check(ac_oe_n, 1'b0);
    cmd(4'h0, {4'h0, 2'h1, 12'h0, `CW_IDX_FLOAT}, 1'b0);
    settle();
    check(ac_oe_n, 1'b1);
    done("quad");
    print_verdict();
  end
endmodule
`default_nettype wire
